// ### common/dsa_cfg.svh
// Address map, reset values and step sizes of the data-space access unit.
`ifndef DSA_CFG_SVH
`define DSA_CFG_SVH

`define DSA_WINDOW_BIT 15
`define DSA_CTRL_TOP 16'h07FF
`define DSA_NEAR_TOP 16'h1FFF
`define DSA_RAM_TOP 16'h3FFF
`define DSA_NEAR_BITS 13
`define DSA_RAM_AW 13
`define DSA_RAM_WORDS 8192
`define DSA_STEP_BYTE 16'h0001
`define DSA_STEP_WORD 16'h0002
`define DSA_ZERO_WORD 16'h0000
`define DSA_ZERO_BYTE 8'h00
`define DSA_TRAP_FLAG_RST 1'b0

`endif

// ### common/dsa_pkg.sv
// Types shared by the data-space access unit and its leaf modules.
package dsa_pkg;

    typedef enum logic [1:0] {
        DSA_MODE_INDIRECT,
        DSA_MODE_DIRECT16,
        DSA_MODE_NEAR13
    } dsa_mode_t;

    typedef enum logic [1:0] {
        DSA_OP_LOAD_WORD,
        DSA_OP_LOAD_BYTE,
        DSA_OP_SIGN_WIDEN,
        DSA_OP_CLEAR_UPPER
    } dsa_wop_t;

    typedef enum logic [1:0] {
        DSA_REGION_RAM,
        DSA_REGION_CTRL,
        DSA_REGION_WINDOW,
        DSA_REGION_NONE
    } dsa_region_t;

    typedef struct packed {
        logic valid;
        logic is_byte;
        dsa_mode_t mode;
        logic [15:0] pointer_register;
        logic [15:0] direct_addr;
        logic post_inc;
        logic [15:0] wreg_old;
    } dsa_rd_req_t;

    typedef struct packed {
        logic valid;
        logic is_byte;
        dsa_mode_t mode;
        logic [15:0] pointer_register;
        logic [15:0] direct_addr;
        logic post_inc;
        logic [15:0] data;
    } dsa_wr_req_t;

    typedef struct packed {
        logic valid;
        dsa_wop_t op;
        logic [15:0] value;
    } dsa_ext_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
        logic [15:0] wreg;
        logic [15:0] pointer_register;
    } dsa_rd_ans_t;

    typedef struct packed {
        logic done;
        logic suppressed;
        logic [15:0] pointer_register;
    } dsa_wr_ans_t;

    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } dsa_ext_ans_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
        logic [1:0] lane_en;
    } dsa_bus_wr_t;

    typedef struct packed {
        dsa_rd_ans_t rd;
        dsa_wr_ans_t wr;
        dsa_ext_ans_t ext;
        dsa_bus_wr_t ctrl_wr;
        dsa_bus_wr_t window_wr;
        logic trap_pulse;
        logic trap_flag;
    } dsa_state_t;

endpackage : dsa_pkg

// ### core/dsa_byte_lane.sv
// One byte-wide lane of the data memory with its own write enable.
`timescale 1ns/10ps
`default_nettype none
`include "dsa_cfg.svh"

module dsa_byte_lane (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [`DSA_RAM_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [`DSA_RAM_AW-1:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] mem [0:`DSA_RAM_WORDS-1];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // The read is asynchronous so that the unit can register the answer itself.
    assign rdata = mem[raddr];

endmodule : dsa_byte_lane

`default_nettype wire

// ### core/dsa_wreg_merge.sv
// Merges loaded data into a working register and performs the widening operations.
`timescale 1ns/10ps
`default_nettype none
`include "dsa_cfg.svh"

module dsa_wreg_merge
    import dsa_pkg::*;
(
    input wire logic [15:0] old_value,
    input wire logic [15:0] load_value,
    input wire dsa_wop_t op,
    output logic [15:0] new_value
);

    always_comb begin
        unique case (op)
            DSA_OP_LOAD_WORD: new_value = load_value;
            DSA_OP_LOAD_BYTE: new_value = {old_value[15:8], load_value[7:0]};
            DSA_OP_SIGN_WIDEN: new_value = {{8{old_value[7]}}, old_value[7:0]};
            DSA_OP_CLEAR_UPPER: new_value = {`DSA_ZERO_BYTE, old_value[7:0]};
        endcase
    end

endmodule : dsa_wreg_merge

`default_nettype wire

// ### core/dsa_access_unit.sv
// Data-space access unit: address decode, byte lanes, alignment trap and register merge.
`timescale 1ns/10ps
`default_nettype none
`include "dsa_cfg.svh"

// Notes on behaviour
// - Addresses are 16-bit, each selects one byte.
// - Top bit clear means data memory, set window.
// - Unimplemented data locations read back as zero.
// - Even address is low byte, odd high.
// - Post-increment adds one for bytes, two words.
// - Byte read selects byte onto low lane.
// - Shared word decode, separate per-lane write enables.
// - Odd-address word access raises address error trap.
// - Misaligned read completes; misaligned write is suppressed.
// - Byte load changes only register low byte.
// - Sign-widen and clear-upper operations on registers.
// - Lowest 2 Kbytes belong to control registers.
// - Unused control-register addresses read as zero.
// - Near region reached by 13-bit direct field.
// - Full space via 16-bit direct or pointer.
// - Independent read and write address generators accepted.
// - Sticky trap flag stays set until cleared.

module dsa_access_unit
    import dsa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire dsa_rd_req_t rd_req,
    input wire dsa_wr_req_t wr_req,
    input wire dsa_ext_req_t ext_req,
    output dsa_rd_ans_t rd_ans,
    output dsa_wr_ans_t wr_ans,
    output dsa_ext_ans_t ext_ans,
    output logic ctrl_rd_en,
    output logic [15:0] ctrl_rd_addr,
    input wire logic [15:0] ctrl_rd_data,
    input wire logic ctrl_rd_hit,
    output dsa_bus_wr_t ctrl_wr,
    output logic window_rd_en,
    output logic [15:0] window_rd_addr,
    input wire logic [15:0] window_rd_data,
    output dsa_bus_wr_t window_wr,
    output logic trap_pulse,
    output logic misaligned_access_trap_flag,
    input wire logic trap_flag_clr
);

    localparam dsa_state_t ST_RESET = '0;

    dsa_state_t st;
    dsa_state_t next_st;

    logic [15:0] rd_ea;
    logic [15:0] wr_ea;
    dsa_region_t rd_region;
    dsa_region_t wr_region;
    logic rd_misaligned;
    logic wr_misaligned;
    logic wr_ok;
    logic lo_we;
    logic hi_we;
    logic [7:0] lo_wdata;
    logic [7:0] hi_wdata;
    logic [7:0] lo_rdata;
    logic [7:0] hi_rdata;
    logic [15:0] rd_word;
    logic [15:0] rd_value;
    logic [15:0] rd_merged;
    logic [15:0] ext_value;
    dsa_wop_t rd_op;

    // Forms the byte address from the addressing mode of a request.
    function automatic logic [15:0] ea_of(
        input dsa_mode_t mode,
        input logic [15:0] ptr,
        input logic [15:0] dir
    );
        logic [15:0] ea;
        ea = dir;
        unique case (mode)
            DSA_MODE_INDIRECT: ea = ptr;
            DSA_MODE_DIRECT16: ea = dir;
            DSA_MODE_NEAR13: ea = {3'b000, dir[`DSA_NEAR_BITS-1:0]};
            default: ea = dir;
        endcase
        return ea;
    endfunction : ea_of

    // Sorts a byte address into the region that answers it.
    function automatic dsa_region_t region_of(input logic [15:0] ea);
        dsa_region_t r;
        if (ea[`DSA_WINDOW_BIT]) begin
            r = DSA_REGION_WINDOW;
        end else if (ea <= `DSA_CTRL_TOP) begin
            r = DSA_REGION_CTRL;
        end else if (ea <= `DSA_RAM_TOP) begin
            r = DSA_REGION_RAM;
        end else begin
            r = DSA_REGION_NONE;
        end
        return r;
    endfunction : region_of

    // Advances a pointer by the operand size when post-increment is asked.
    function automatic logic [15:0] step_of(
        input logic [15:0] ptr,
        input logic inc,
        input logic is_byte
    );
        logic [15:0] p;
        p = ptr;
        if (inc) begin
            p = ptr + (is_byte ? `DSA_STEP_BYTE : `DSA_STEP_WORD);
        end
        return p;
    endfunction : step_of

    // Read and write addresses are decoded independently so both may act in one cycle.
    assign rd_ea = ea_of(rd_req.mode, rd_req.pointer_register, rd_req.direct_addr);
    assign wr_ea = ea_of(wr_req.mode, wr_req.pointer_register, wr_req.direct_addr);
    assign rd_region = region_of(rd_ea);
    assign wr_region = region_of(wr_ea);
    assign rd_misaligned = rd_req.valid & ~rd_req.is_byte & rd_ea[0];
    assign wr_misaligned = wr_req.valid & ~wr_req.is_byte & wr_ea[0];
    assign wr_ok = wr_req.valid & ~wr_misaligned;

    // Each lane has its own enable, so a byte write leaves the other lane intact.
    assign lo_we = wr_ok & (wr_region == DSA_REGION_RAM) & (~wr_req.is_byte | ~wr_ea[0]);
    assign hi_we = wr_ok & (wr_region == DSA_REGION_RAM) & (~wr_req.is_byte | wr_ea[0]);
    assign lo_wdata = wr_req.data[7:0];
    assign hi_wdata = wr_req.is_byte ? wr_req.data[7:0] : wr_req.data[15:8];

    dsa_byte_lane u_lane_lo (
        .sys_clk(sys_clk),
        .we(lo_we),
        .waddr(wr_ea[`DSA_RAM_AW:1]),
        .wdata(lo_wdata),
        .raddr(rd_ea[`DSA_RAM_AW:1]),
        .rdata(lo_rdata)
    );

    dsa_byte_lane u_lane_hi (
        .sys_clk(sys_clk),
        .we(hi_we),
        .waddr(wr_ea[`DSA_RAM_AW:1]),
        .wdata(hi_wdata),
        .raddr(rd_ea[`DSA_RAM_AW:1]),
        .rdata(hi_rdata)
    );

    // Control-register and window reads must answer in the cycle of the request.
    assign ctrl_rd_en = rd_req.valid & (rd_region == DSA_REGION_CTRL);
    assign ctrl_rd_addr = rd_ea;
    assign window_rd_en = rd_req.valid & (rd_region == DSA_REGION_WINDOW);
    assign window_rd_addr = rd_ea;

    always_comb begin
        unique case (rd_region)
            DSA_REGION_RAM: rd_word = {hi_rdata, lo_rdata};
            DSA_REGION_CTRL: rd_word = ctrl_rd_hit ? ctrl_rd_data : `DSA_ZERO_WORD;
            DSA_REGION_WINDOW: rd_word = window_rd_data;
            DSA_REGION_NONE: rd_word = `DSA_ZERO_WORD;
        endcase
    end

    // The whole word is fetched and the addressed byte moved onto the low lane.
    assign rd_value = rd_req.is_byte
        ? {`DSA_ZERO_BYTE, (rd_ea[0] ? rd_word[15:8] : rd_word[7:0])}
        : rd_word;
    assign rd_op = rd_req.is_byte ? DSA_OP_LOAD_BYTE : DSA_OP_LOAD_WORD;

    dsa_wreg_merge u_merge_rd (
        .old_value(rd_req.wreg_old),
        .load_value(rd_value),
        .op(rd_op),
        .new_value(rd_merged)
    );

    dsa_wreg_merge u_merge_ext (
        .old_value(ext_req.value),
        .load_value(`DSA_ZERO_WORD),
        .op(ext_req.op),
        .new_value(ext_value)
    );

    always_comb begin
        next_st = st;

        // A misaligned read still completes with the aligned word.
        next_st.rd.valid = rd_req.valid;
        next_st.rd.data = rd_value;
        next_st.rd.wreg = rd_merged;
        next_st.rd.pointer_register = step_of(rd_req.pointer_register, rd_req.post_inc,
            rd_req.is_byte);

        // A misaligned write updates the pointer but never reaches any target.
        next_st.wr.done = wr_req.valid;
        next_st.wr.suppressed = wr_misaligned;
        next_st.wr.pointer_register = step_of(wr_req.pointer_register, wr_req.post_inc,
            wr_req.is_byte);

        next_st.ext.valid = ext_req.valid;
        next_st.ext.value = ext_value;

        next_st.ctrl_wr.valid = wr_ok & (wr_region == DSA_REGION_CTRL);
        next_st.ctrl_wr.addr = wr_ea;
        next_st.ctrl_wr.data = {hi_wdata, lo_wdata};
        next_st.ctrl_wr.lane_en = {hi_we | (wr_ok & (~wr_req.is_byte | wr_ea[0])),
            (wr_ok & (~wr_req.is_byte | ~wr_ea[0]))};

        next_st.window_wr.valid = wr_ok & (wr_region == DSA_REGION_WINDOW);
        next_st.window_wr.addr = wr_ea;
        next_st.window_wr.data = {hi_wdata, lo_wdata};
        next_st.window_wr.lane_en = next_st.ctrl_wr.lane_en;

        next_st.trap_pulse = rd_misaligned | wr_misaligned;
        // A new trap in the clearing cycle keeps the flag set.
        if (rd_misaligned | wr_misaligned) begin
            next_st.trap_flag = 1'b1;
        end else if (trap_flag_clr) begin
            next_st.trap_flag = `DSA_TRAP_FLAG_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rd_ans = st.rd;
    assign wr_ans = st.wr;
    assign ext_ans = st.ext;
    assign ctrl_wr = st.ctrl_wr;
    assign window_wr = st.window_wr;
    assign trap_pulse = st.trap_pulse;
    assign misaligned_access_trap_flag = st.trap_flag;

endmodule : dsa_access_unit

`default_nettype wire

// ### testbench/dsa_far_model.sv
// Far-side responders for the control-register and window read ports.
`timescale 1ns/10ps
`default_nettype none
module dsa_far_model (
    input wire logic ctrl_rd_en,
    input wire logic [15:0] ctrl_rd_addr,
    input wire logic window_rd_en,
    input wire logic [15:0] window_rd_addr,
    output logic [15:0] ctrl_rd_data,
    output logic ctrl_rd_hit,
    output logic [15:0] window_rd_data
);
    // Only the word at 0x0040 holds a register, so the rest of the region is unused.
    assign ctrl_rd_hit = ctrl_rd_en && ctrl_rd_addr[15:1] == 15'h0020;
    // A miss still shows a busy pattern, so a design that ignores the hit flag is caught.
    assign ctrl_rd_data = ctrl_rd_hit ? 16'hc35a : 16'h5a5a;
    assign window_rd_data = window_rd_en ? {window_rd_addr[7:0], 8'h3c} : 16'hffff;
endmodule : dsa_far_model
`default_nettype wire

// ### testbench/dsa_access_unit_chk.sv
// Port-level assertions for the data-space access unit, bound into its top module.
`timescale 1ns/10ps
`default_nettype none
module dsa_access_unit_chk
    import dsa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire dsa_rd_req_t rd_req,
    input wire dsa_wr_req_t wr_req,
    input wire dsa_rd_ans_t rd_ans,
    input wire dsa_wr_ans_t wr_ans,
    input wire logic ctrl_rd_en,
    input wire logic ctrl_rd_hit,
    input wire dsa_bus_wr_t ctrl_wr,
    input wire logic window_rd_en,
    input wire logic [15:0] window_rd_addr,
    input wire dsa_bus_wr_t window_wr,
    input wire logic trap_pulse,
    input wire logic misaligned_access_trap_flag,
    input wire logic trap_flag_clr
);
    logic [15:0] rea;
    logic [15:0] wea;
    logic rmis;
    logic wmis;
    function automatic logic [15:0] ea(input dsa_mode_t m, input logic [15:0] p, d);
        return m == DSA_MODE_INDIRECT ? p : m == DSA_MODE_DIRECT16 ? d : {3'h0, d[12:0]};
    endfunction : ea
    assign rea = ea(rd_req.mode, rd_req.pointer_register, rd_req.direct_addr);
    assign wea = ea(wr_req.mode, wr_req.pointer_register, wr_req.direct_addr);
    assign rmis = rd_req.valid && !rd_req.is_byte && rea[0];
    assign wmis = wr_req.valid && !wr_req.is_byte && wea[0];
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    chk_rd_answer: assert property (rd_req.valid |=> rd_ans.valid)
        else $error("read got no answer");
    chk_wr_answer: assert property (wr_req.valid |=> wr_ans.done)
        else $error("write got no done");
    chk_trap_cause: assert property (rmis || wmis |=> trap_pulse)
        else $error("misaligned access without trap");
    chk_trap_only: assert property (!(rmis || wmis) |=> !trap_pulse)
        else $error("trap without misaligned access");
    chk_flag_hold: assert property (
        misaligned_access_trap_flag && !trap_flag_clr |=> misaligned_access_trap_flag)
        else $error("trap flag lost");
    chk_flag_clear: assert property (
        trap_flag_clr && !rmis && !wmis |=> !misaligned_access_trap_flag)
        else $error("trap flag not cleared");
    chk_write_drop: assert property (wmis |=> wr_ans.suppressed
        && !ctrl_wr.valid && !window_wr.valid)
        else $error("misaligned write not dropped");
    chk_window_route: assert property (rd_req.valid && rea[15] |-> window_rd_en
        && window_rd_addr == rea && !ctrl_rd_en)
        else $error("window read misrouted");
    chk_ctrl_miss: assert property (rd_req.valid && rea <= 16'h07ff
        && !ctrl_rd_hit |=> rd_ans.data == 16'h0000)
        else $error("unused control address not zero");
    chk_ptr_step: assert property (rd_req.valid && rd_req.post_inc
        && rd_req.mode == DSA_MODE_INDIRECT |=> rd_ans.pointer_register
        == $past(rd_req.pointer_register) + ($past(rd_req.is_byte) ? 16'h0001 : 16'h0002))
        else $error("pointer step wrong");
    cover property (rmis);
    cover property (wmis);
    cover property (trap_flag_clr && misaligned_access_trap_flag);
endmodule : dsa_access_unit_chk
bind dsa_access_unit dsa_access_unit_chk chk_u (.sys_clk, .sys_rst, .rd_req, .wr_req,
    .rd_ans, .wr_ans, .ctrl_rd_en, .ctrl_rd_hit, .ctrl_wr, .window_rd_en, .window_rd_addr,
    .window_wr, .trap_pulse, .misaligned_access_trap_flag, .trap_flag_clr);
`default_nettype wire

// ### testbench/dsa_access_unit_bench.sv
// Self-checking testbench for the data-space access unit.
`timescale 1ns/10ps
`default_nettype none
module dsa_access_unit_bench
    import dsa_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    dsa_rd_req_t rd_req = '0;
    dsa_wr_req_t wr_req = '0;
    dsa_ext_req_t ext_req = '0;
    logic trap_flag_clr = 1'b0;
    dsa_rd_ans_t rd_ans;
    dsa_wr_ans_t wr_ans;
    dsa_ext_ans_t ext_ans;
    logic ctrl_rd_en;
    logic [15:0] ctrl_rd_addr;
    logic [15:0] ctrl_rd_data;
    logic ctrl_rd_hit;
    dsa_bus_wr_t ctrl_wr;
    logic window_rd_en;
    logic [15:0] window_rd_addr;
    logic [15:0] window_rd_data;
    dsa_bus_wr_t window_wr;
    logic trap_pulse;
    logic misaligned_access_trap_flag;
    int errors = 0;
    int total_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    dsa_access_unit dut_u (.sys_clk, .sys_rst, .rd_req, .wr_req, .ext_req, .rd_ans, .wr_ans,
        .ext_ans, .ctrl_rd_en, .ctrl_rd_addr, .ctrl_rd_data, .ctrl_rd_hit, .ctrl_wr,
        .window_rd_en, .window_rd_addr, .window_rd_data, .window_wr, .trap_pulse,
        .misaligned_access_trap_flag, .trap_flag_clr);
    dsa_far_model far_u (.ctrl_rd_en, .ctrl_rd_addr, .window_rd_en, .window_rd_addr,
        .ctrl_rd_data, .ctrl_rd_hit, .window_rd_data);
    task automatic ck(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : ck
    // Answers are registered, so looking 1 ns past the edge sees them settled.
    task automatic go;
        @(posedge sys_clk);
        rd_req.valid <= 1'b0;
        wr_req.valid <= 1'b0;
        ext_req.valid <= 1'b0;
        #1;
    endtask : go
    task automatic rd(input dsa_mode_t m, input logic b, input logic [15:0] a, w);
        @(posedge sys_clk);
        rd_req <= '{1'b1, b, m, a, a, 1'b1, w};
        go();
    endtask : rd
    task automatic wr(input dsa_mode_t m, input logic b, input logic [15:0] a, d);
        @(posedge sys_clk);
        wr_req <= '{1'b1, b, m, a, a, 1'b1, d};
        go();
    endtask : wr
    task automatic t_ram;
        wr(DSA_MODE_INDIRECT, 1'b0, 16'h0900, 16'hbeef);
        ck(16'(wr_ans.done), 16'h0001);
        ck(wr_ans.pointer_register, 16'h0902);
        wr(DSA_MODE_INDIRECT, 1'b1, 16'h0901, 16'h0012);
        ck(wr_ans.pointer_register, 16'h0902);
        rd(DSA_MODE_INDIRECT, 1'b1, 16'h0901, 16'haaaa);
        ck(rd_ans.data, 16'h0012);
        ck(rd_ans.wreg, 16'haa12);
        ck(rd_ans.pointer_register, 16'h0902);
        rd(DSA_MODE_DIRECT16, 1'b0, 16'h0900, 16'h0000);
        ck(rd_ans.data, 16'h12ef);
        rd(DSA_MODE_NEAR13, 1'b0, 16'he900, 16'h0000);
        ck(rd_ans.data, 16'h12ef);
        @(posedge sys_clk);
        rd_req <= '{1'b1, 1'b0, DSA_MODE_DIRECT16, 16'h0900, 16'h0900, 1'b0, 16'h0000};
        wr_req <= '{1'b1, 1'b1, DSA_MODE_DIRECT16, 16'h0900, 16'h0900, 1'b0, 16'h0055};
        go();
        ck(rd_ans.data, 16'h12ef);
        rd(DSA_MODE_DIRECT16, 1'b0, 16'h0900, 16'h0000);
        ck(rd_ans.data, 16'h1255);
        $display("t_ram done");
    endtask : t_ram
    task automatic t_zero;
        rd(DSA_MODE_DIRECT16, 1'b0, 16'h4000, 16'h0000);
        ck(rd_ans.data, 16'h0000);
        rd(DSA_MODE_DIRECT16, 1'b0, 16'h0100, 16'h0000);
        ck(rd_ans.data, 16'h0000);
        rd(DSA_MODE_DIRECT16, 1'b1, 16'h0041, 16'h0000);
        ck(rd_ans.data, 16'h00c3);
        wr(DSA_MODE_DIRECT16, 1'b1, 16'h0041, 16'h0077);
        ck({ctrl_wr.valid, 13'h0000, ctrl_wr.lane_en}, 16'h8002);
        ck(ctrl_wr.data, 16'h7777);
        ck(ctrl_wr.addr, 16'h0041);
        $display("t_zero done");
    endtask : t_zero
    task automatic t_win;
        wr(DSA_MODE_INDIRECT, 1'b0, 16'h8004, 16'h4321);
        ck({window_wr.valid, ctrl_wr.valid, 14'h0000}, 16'h8000);
        ck(window_wr.addr, 16'h8004);
        ck(window_wr.data, 16'h4321);
        rd(DSA_MODE_INDIRECT, 1'b0, 16'h8004, 16'h0000);
        ck(rd_ans.data, 16'h043c);
        $display("t_win done");
    endtask : t_win
    task automatic t_trap;
        // The odd word write aims at the word that already holds 16'h1255, so a lost
        // suppression shows up in the read that follows.
        wr(DSA_MODE_DIRECT16, 1'b0, 16'h0901, 16'h9999);
        ck({wr_ans.suppressed, trap_pulse, misaligned_access_trap_flag, 13'h0}, 16'he000);
        rd(DSA_MODE_DIRECT16, 1'b0, 16'h0901, 16'h0000);
        ck({rd_ans.valid, trap_pulse, 14'h0000}, 16'hc000);
        ck(16'(misaligned_access_trap_flag), 16'h0001);
        ck(rd_ans.data, 16'h1255);
        @(posedge sys_clk);
        trap_flag_clr <= 1'b1;
        @(posedge sys_clk);
        trap_flag_clr <= 1'b0;
        #1;
        ck(16'(misaligned_access_trap_flag), 16'h0000);
        // A new trap in the clearing cycle must leave the flag set.
        @(posedge sys_clk);
        rd_req <= '{1'b1, 1'b0, DSA_MODE_DIRECT16, 16'h0901, 16'h0901, 1'b0, 16'h0000};
        trap_flag_clr <= 1'b1;
        @(posedge sys_clk);
        rd_req.valid <= 1'b0;
        trap_flag_clr <= 1'b0;
        #1;
        ck(16'(misaligned_access_trap_flag), 16'h0001);
        $display("t_trap done");
    endtask : t_trap
    task automatic t_ext;
        @(posedge sys_clk);
        ext_req <= '{1'b1, DSA_OP_SIGN_WIDEN, 16'h1280};
        go();
        ck(ext_ans.value, 16'hff80);
        ck(16'(ext_ans.valid), 16'h0001);
        @(posedge sys_clk);
        ext_req <= '{1'b1, DSA_OP_CLEAR_UPPER, 16'hff80};
        go();
        ck(ext_ans.value, 16'h0080);
        $display("t_ext done");
    endtask : t_ext
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        go();
        ck(16'(misaligned_access_trap_flag), 16'h0000);
        t_ram();
        t_zero();
        t_win();
        t_trap();
        t_ext();
        summarize();
    end
    initial begin
        #100000;
        errors++;
        summarize();
    end
endmodule : dsa_access_unit_bench
`default_nettype wire
